// file: common/prot_defines.svh
// offsets, field positions, reset values and timing for the protection unit
// What this block does
// [R1] check physical address only, pass it unchanged
// [R2] protection off: every access uses default map
// [R3] private peripheral bus always uses default map
// [R4] vector table reads always use default map
// [R5] addresses from 0xE0000000 up are execute-never
// [R6] negative priority: nmi check enable picks regions
// [R7] core flags negative priority in nmi/hard_fault_handler/mask
// [R8] background default map for unmatched privileged accesses
// [R9] overlapping regions: highest region number wins
// [R10] enabled, no region or background match: fault
// [R11] enable bit zero: all accesses use default
// [R12] disabled: fetch from execute-never default region faults
// [R13] disabled: data accesses never checked or aborted
// [R14] one unified region set for fetch and data
// [R15] software aligns each base to region size
// [R16] region sizes two to N, N 5..32
// [R17] regions of 256 bytes up: eight subregions
// [R18] disabled subregion needs other match, else fault
// [R19] software keeps subregion disables zero below 256
// [R20] base write may select region, numbers 0..15; code accepts only numbers below NREG
// [R21] base/attribute pair aliased three more times
// [R22] region count fixed in hardware, readable
// [R23] attribute bit 0 enables; bits 5:1 size code
// [R24] execute-never at bit 28, permissions bits 26:24
// [R25] fault flags: fetch vs data, address capture
// [R26] fixed one-cycle lookup latency, no history
`ifndef PROT_DEFINES_SVH
`define PROT_DEFINES_SVH

// register byte offsets inside the 256-byte window
`define PROT_OFF_TYPE      8'h00
`define PROT_OFF_CTRL      8'h04
`define PROT_OFF_RNUM      8'h08
`define PROT_OFF_BASE      8'h0C
`define PROT_OFF_ATTR      8'h10
`define PROT_OFF_ALIAS_END 8'h28
`define PROT_OFF_FSTAT     8'h30
`define PROT_OFF_FADDR     8'h34

// control bits
`define PROT_CTRL_ENABLE   0
`define PROT_CTRL_HFNMI    1
`define PROT_CTRL_PRIVDEF  2
`define PROT_CTRL_RESET    3'h0

// type register: region count field low bit
`define PROT_TYPE_COUNT_LSB 8

// base register fields
`define PROT_BASE_VALID    4
`define PROT_BASE_LSB      5
`define PROT_BASE_MAX_SEL  8'h0F

// attribute/size register fields
`define PROT_ATTR_EN       0
`define PROT_ATTR_SIZE_LSB 1
`define PROT_ATTR_SRD_LSB  8
`define PROT_ATTR_TEX_LSB  16
`define PROT_ATTR_AP_LSB   24
`define PROT_ATTR_XN       28
`define PROT_ATTR_RESET    32'h0000_0000

// fault status bits
`define PROT_FST_IACC      0
`define PROT_FST_DACC      1
`define PROT_FST_AVALID    7

// address map constants
`define PROT_PPB_TOP       12'hE00
`define PROT_SYS_TOP       3'h7
`define PROT_DEF_XN_MASK   8'hE4
`define PROT_DEF_AP        3'h3
`define PROT_MIN_LSBIT     6'h05
`define PROT_SUB_LSBIT     6'h08
`define PROT_FULL_LSBIT    6'h20

// lookup latency in clock cycles
`define PROT_LOOKUP_LAT    1

`endif

// file: common/prot_pkg.sv
// types shared by the protection unit and its users
package prot_pkg;

  // kind of access presented on the lookup port
  typedef enum logic [1:0] {
    ACC_DATA    = 2'h0,
    ACC_IFETCH  = 2'h1,
    ACC_VECTAB  = 2'h3
  } acc_t;

  // bus response codes
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'h0,
    RESP_SLVERR = 2'h2
  } resp_t;

endpackage : prot_pkg

// file: hw/memory_protection_unit.sv
// region-based memory protection unit with lookup port and lite slave
`timescale 1ns/1ps
`include "prot_defines.svh"

module memory_protection_unit #(
  parameter int NREG = 8
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               sys_rst,
  // lookup request from the core
  input  wire logic               lk_valid,
  input  wire logic [31:0]        lk_addr,
  input  prot_pkg::acc_t          lk_type,
  input  wire logic               lk_write,
  input  wire logic               lk_priv,
  input  wire logic               lk_pri_neg,
  // lookup result
  output logic                    rs_valid,
  output logic [31:0]             rs_addr,
  output logic                    rs_fault,
  output logic                    rs_execute_never,
  output logic [2:0]              rs_ap,
  output logic [5:0]              rs_attr,
  output logic                    rs_region_hit,
  output logic [3:0]              rs_region,
  // lite write address and data
  input  wire logic [31:0]        s_awaddr,
  input  wire logic               s_awvalid,
  output logic                    s_awready,
  input  wire logic [31:0]        s_wdata,
  input  wire logic [3:0]         s_wstrb,
  input  wire logic               s_wvalid,
  output logic                    s_wready,
  // lite write response
  output logic [1:0]              s_bresp,
  output logic                    s_bvalid,
  input  wire logic               s_bready,
  // lite read
  input  wire logic [31:0]        s_araddr,
  input  wire logic               s_arvalid,
  output logic                    s_arready,
  output logic [31:0]             s_rdata,
  output logic [1:0]              s_rresp,
  output logic                    s_rvalid,
  input  wire logic               s_rready
);

  localparam int RW = (NREG > 1) ? $clog2(NREG) : 1;
  localparam logic [7:0] NREG_C = 8'(NREG); // [R22]

  // programmed state
  logic [2:0]  ctrl_q;
  logic [7:0]  rnum_q;
  logic [31:0] base_q [NREG];
  logic [31:0] attr_q [NREG];
  logic        iacc_q;
  logic        dacc_q;
  logic        avalid_q;
  logic [31:0] faddr_q;

  // ------------------------------------------------------------ lookup
  // per-region match; the one set serves fetches and data alike
  logic [NREG-1:0] match_w;
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_reg
      wire [5:0]  lsbit = 6'(attr_q[g][5:1]) + 6'h01; // [R23]
      wire        size_ok = (lsbit >= `PROT_MIN_LSBIT); // [R16]
      wire [31:0] mask = (lsbit == `PROT_FULL_LSBIT) ? 32'h0000_0000
                         : (32'hFFFF_FFFF << lsbit);
      wire        addr_hit = (((lk_addr ^ base_q[g]) & mask) == 32'h0);
      wire [2:0]  sub = 3'(lk_addr >> (lsbit - 6'h03));
      // small regions ignore the disables; software keeps them zero
      wire        sub_off = (lsbit >= `PROT_SUB_LSBIT) &&
                            attr_q[g][`PROT_ATTR_SRD_LSB + sub]; // [R17]
      assign match_w[g] = attr_q[g][`PROT_ATTR_EN] && size_ok &&
                          addr_hit && !sub_off; // [R14] [R18]
    end
  endgenerate

  // highest numbered match wins, so scan upward and keep the last
  logic          any_match;
  logic [RW-1:0] win_idx;
  always_comb begin
    any_match = 1'b0;
    win_idx   = '0;
    for (int i = 0; i < NREG; i++) begin
      if (match_w[i]) begin
        any_match = 1'b1;
        win_idx   = RW'(i); // [R9]
      end
    end
  end

  // access classification
  wire is_fetch  = (lk_type == prot_pkg::ACC_IFETCH);
  wire is_vectab = (lk_type == prot_pkg::ACC_VECTAB);
  wire is_ppb    = (lk_addr[31:20] == `PROT_PPB_TOP);
  wire is_sys    = (lk_addr[31:29] == `PROT_SYS_TOP);
  wire ena       = ctrl_q[`PROT_CTRL_ENABLE];
  wire hfnmi     = ctrl_q[`PROT_CTRL_HFNMI];
  wire privdef   = ctrl_q[`PROT_CTRL_PRIVDEF];
  // one execute-never bit per 512 MB slice of the default map
  wire [7:0] xn_map = `PROT_DEF_XN_MASK;
  wire def_xn    = xn_map[lk_addr[31:29]];

  // default map is forced for these cases before regions are looked at
  wire force_def = is_vectab || is_ppb || !ena ||
                   (!hfnmi && lk_pri_neg); // [R2] [R3] [R4] [R6] [R11]
  wire use_reg   = !force_def && any_match;
  wire bg_hit    = !force_def && !any_match && privdef &&
                   (lk_priv || is_vectab); // [R8]
  wire hit       = force_def || use_reg || bg_hit; // [R10]

  wire [31:0] win_attr = attr_q[win_idx];
  wire [2:0]  perm_ap  = use_reg ? win_attr[`PROT_ATTR_AP_LSB +: 3]
                                 : `PROT_DEF_AP; // [R24]
  // system space is never executable, whatever the region says
  wire perm_xn = is_sys || (use_reg ? win_attr[`PROT_ATTR_XN]
                                    : def_xn); // [R5] [R24]
  wire [5:0] perm_attr = use_reg ? {win_attr[21:19], win_attr[18:16]}
                                 : 6'h00;

  // access permission decode; reserved code 100 denies everything
  logic ap_ok;
  always_comb begin
    ap_ok = 1'b0;
    if (lk_priv || is_vectab) begin
      case (perm_ap)
        3'h1, 3'h2, 3'h3: ap_ok = 1'b1;
        3'h5, 3'h6, 3'h7: ap_ok = !lk_write;
        default:          ap_ok = 1'b0;
      endcase
    end else begin
      case (perm_ap)
        3'h3:             ap_ok = 1'b1;
        3'h2, 3'h6, 3'h7: ap_ok = !lk_write;
        default:          ap_ok = 1'b0;
      endcase
    end
  end

  // disabled unit: default ap is full access, so only fetch xn faults
  wire lk_fault = lk_valid &&
                  (!hit || !ap_ok || (is_fetch && perm_xn)); // [R10] [R12] [R13]

  // result registers: one fixed cycle, nothing carried between lookups
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rs_valid         <= 1'b0;
      rs_addr          <= 32'h0000_0000;
      rs_fault         <= 1'b0;
      rs_execute_never <= 1'b0;
      rs_ap            <= 3'h0;
      rs_attr          <= 6'h00;
      rs_region_hit    <= 1'b0;
      rs_region        <= 4'h0;
    end else begin
      rs_valid         <= lk_valid; // [R26]
      rs_addr          <= lk_addr; // [R1]
      rs_fault         <= lk_fault;
      rs_execute_never <= perm_xn;
      rs_ap            <= perm_ap;
      rs_attr          <= perm_attr;
      rs_region_hit    <= lk_valid && use_reg;
      rs_region        <= 4'(win_idx);
    end
  end

  // ------------------------------------------------------------ bus
  // accept address and data together, one outstanding write
  wire aw_take = s_awvalid && s_wvalid && !s_awready && !s_bvalid;
  wire ar_take = s_arvalid && !s_arready && !s_rvalid;
  wire wr_fire = s_awready; // ready pulses only while both are held
  wire rd_fire = s_arready;

  wire [7:0] woff = s_awaddr[7:0];
  wire [7:0] roff = s_araddr[7:0];
  wire w_full = (s_wstrb == 4'hF); // word access only
  // base and attribute pair repeats every eight bytes up to alias 3
  wire w_pair = (woff >= `PROT_OFF_BASE) && (woff <= `PROT_OFF_ALIAS_END);
  wire r_pair = (roff >= `PROT_OFF_BASE) && (roff <= `PROT_OFF_ALIAS_END);
  wire w_base = w_pair && woff[2]; // [R21]
  wire w_attr = w_pair && !woff[2]; // [R21]
  wire w_ctrl = (woff == `PROT_OFF_CTRL);
  wire w_rnum = (woff == `PROT_OFF_RNUM);
  wire w_fst  = (woff == `PROT_OFF_FSTAT);
  wire w_ro   = (woff == `PROT_OFF_TYPE) || (woff == `PROT_OFF_FADDR);
  wire w_map  = w_base || w_attr || w_ctrl || w_rnum || w_fst || w_ro;
  wire w_ok   = w_map && w_full;
  wire w_en   = wr_fire && w_ok && !w_ro;

  // region select on a base write, valid only for numbers below the region count
  wire [7:0] sel_num  = {4'h0, s_wdata[3:0]};
  wire       sel_new  = w_base && s_wdata[`PROT_BASE_VALID] &&
                        (sel_num <= `PROT_BASE_MAX_SEL) &&
                        (sel_num < NREG_C); // [R20]
  wire [7:0] tgt_num  = sel_new ? sel_num : rnum_q;
  wire       tgt_ok   = (tgt_num < NREG_C);
  wire [RW-1:0] tgt   = RW'(tgt_num);
  wire       rnum_ok  = (s_wdata[7:0] < NREG_C);

  // read mux
  wire [RW-1:0] rsel  = RW'(rnum_q);
  wire       rsel_ok  = (rnum_q < NREG_C);
  wire [31:0] rd_base = rsel_ok ? {base_q[rsel][31:4], rnum_q[3:0]}
                                : {28'h0, rnum_q[3:0]};
  wire [31:0] rd_attr = rsel_ok ? attr_q[rsel] : 32'h0000_0000;
  wire [31:0] rd_type = {16'h0, NREG_C, 8'h00}; // [R22]
  wire [31:0] rd_fst  = {24'h0, avalid_q, 5'h00, dacc_q, iacc_q};
  wire        r_map   = r_pair || (roff == `PROT_OFF_TYPE) ||
                        (roff == `PROT_OFF_CTRL) || (roff == `PROT_OFF_RNUM) ||
                        (roff == `PROT_OFF_FSTAT) || (roff == `PROT_OFF_FADDR);
  wire [31:0] rd_mux  =
      r_pair                      ? (roff[2] ? rd_base : rd_attr) :
      (roff == `PROT_OFF_TYPE)    ? rd_type :
      (roff == `PROT_OFF_CTRL)    ? {29'h0, ctrl_q} :
      (roff == `PROT_OFF_RNUM)    ? {24'h0, rnum_q} :
      (roff == `PROT_OFF_FSTAT)   ? rd_fst :
      (roff == `PROT_OFF_FADDR)   ? faddr_q : 32'h0000_0000;

  // bus handshake registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= prot_pkg::RESP_OKAY;
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rresp   <= prot_pkg::RESP_OKAY;
      s_rdata   <= 32'h0000_0000;
    end else begin
      s_awready <= aw_take;
      s_wready  <= aw_take;
      s_arready <= ar_take;
      if (wr_fire) begin
        s_bvalid <= 1'b1;
        s_bresp  <= w_ok ? prot_pkg::RESP_OKAY : prot_pkg::RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (rd_fire) begin
        s_rvalid <= 1'b1;
        s_rdata  <= r_map ? rd_mux : 32'h0000_0000;
        s_rresp  <= r_map ? prot_pkg::RESP_OKAY : prot_pkg::RESP_SLVERR;
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // control, region number and region registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= `PROT_CTRL_RESET;
      rnum_q <= 8'h00;
      for (int i = 0; i < NREG; i++) begin
        base_q[i] <= 32'h0000_0000;
        attr_q[i] <= `PROT_ATTR_RESET;
      end
    end else if (w_en) begin
      if (w_ctrl) ctrl_q <= s_wdata[2:0];
      if (w_rnum && rnum_ok) rnum_q <= s_wdata[7:0];
      if (sel_new) rnum_q <= sel_num; // [R20]
      // low base bits are kept zero; alignment is up to software
      if (w_base && tgt_ok)
        base_q[tgt] <= {s_wdata[31:`PROT_BASE_LSB], 5'h00}; // [R15]
      if (w_attr && tgt_ok) attr_q[tgt] <= s_wdata;
    end
  end

  // fault capture: a new fault wins over a same-cycle clear
  wire fetch_fault = lk_fault && is_fetch;
  wire data_fault  = lk_fault && !is_fetch;
  wire [31:0] clr  = (w_en && w_fst) ? s_wdata : 32'h0000_0000;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      iacc_q   <= 1'b0;
      dacc_q   <= 1'b0;
      avalid_q <= 1'b0;
      faddr_q  <= 32'h0000_0000;
    end else begin
      iacc_q <= fetch_fault || (iacc_q && !clr[`PROT_FST_IACC]); // [R25]
      dacc_q <= data_fault || (dacc_q && !clr[`PROT_FST_DACC]); // [R25]
      if (data_fault) begin
        avalid_q <= 1'b1; // [R25]
        faddr_q  <= lk_addr;
      end else if (fetch_fault) begin
        avalid_q <= 1'b0; // [R25]
      end else if (clr[`PROT_FST_AVALID]) begin
        avalid_q <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------ checks
  addr_pass_a : assert property (@(posedge clk) disable iff (sys_rst) // [R1]
    lk_valid |=> rs_valid && rs_addr == $past(lk_addr))
    else $error("address not passed through unchanged");

  fixed_lat_a : assert property (@(posedge clk) disable iff (sys_rst) // [R26]
    !lk_valid |=> !rs_valid)
    else $error("result without a lookup");

  off_data_a : assert property (@(posedge clk) disable iff (sys_rst) // [R13]
    lk_valid && !ena && !is_fetch |=> !rs_fault && !rs_region_hit)
    else $error("data access faulted while unit disabled");

  off_fetch_a : assert property (@(posedge clk) disable iff (sys_rst) // [R12]
    lk_valid && !ena && is_fetch && def_xn |=> rs_fault && iacc_q)
    else $error("fetch from execute-never default not faulted");

  sys_xn_a : assert property (@(posedge clk) disable iff (sys_rst) // [R5]
    lk_valid && lk_addr[31:29] == 3'h7 |=> rs_execute_never)
    else $error("system space left executable");

  ppb_default_a : assert property (@(posedge clk) disable iff (sys_rst) // [R3]
    lk_valid && lk_addr[31:20] == 12'hE00 |=> !rs_region_hit && rs_ap == 3'h3)
    else $error("peripheral bus access used a region");

  hfnmi_bypass_a : assert property (@(posedge clk) disable iff (sys_rst) // [R6]
    lk_valid && ena && lk_pri_neg && !hfnmi |=> !rs_region_hit)
    else $error("negative priority access used regions");

  data_fault_a : assert property (@(posedge clk) disable iff (sys_rst) // [R25]
    lk_valid && lk_fault && !is_fetch |=>
      dacc_q && avalid_q && faddr_q == $past(lk_addr))
    else $error("data fault not captured");

  no_match_a : assert property (@(posedge clk) disable iff (sys_rst) // [R10]
    lk_valid && ena && !force_def && !any_match && !privdef |=> rs_fault)
    else $error("unmatched access not faulted");

  bresp_hold_a : assert property (@(posedge clk) disable iff (sys_rst)
    s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
    else $error("write response dropped before taken");

endmodule : memory_protection_unit

// file: test/core_access_model.sv
// core-side model that presents lookups and captures the results
`timescale 1ns/1ps

module core_access_model (
  // clock
  input  wire logic        clk,
  // lookup request towards the unit
  output logic             lk_valid,
  output logic [31:0]      lk_addr,
  output prot_pkg::acc_t   lk_type,
  output logic             lk_write,
  output logic             lk_priv,
  output logic             lk_pri_neg,
  // lookup result from the unit
  input  wire logic        rs_valid,
  input  wire logic [31:0] rs_addr,
  input  wire logic        rs_fault,
  input  wire logic        rs_execute_never,
  input  wire logic        rs_region_hit,
  input  wire logic [3:0]  rs_region
);
  // last result: {valid, fault, xn, hit, region}
  logic [7:0]  got_res;
  logic [31:0] got_addr;

  // idle request lines at time zero
  initial begin
    lk_valid   = 1'b0;
    lk_addr    = 32'h0000_0000;
    lk_type    = prot_pkg::ACC_DATA;
    lk_write   = 1'b0;
    lk_priv    = 1'b0;
    lk_pri_neg = 1'b0;
  end

  // one lookup, result sampled mid-cycle after the answering edge
  task automatic access(input logic [31:0] a, input prot_pkg::acc_t k,
                        input logic wr, input logic pv,
                        input logic hnd, input logic msk);
    @(posedge clk);
    lk_valid   <= 1'b1;
    lk_addr    <= a;
    lk_type    <= k;
    lk_write   <= wr;
    lk_priv    <= pv;
    lk_pri_neg <= hnd | msk;
    @(posedge clk);
    lk_valid   <= 1'b0;
    lk_addr    <= ~a; // stale address must not look valid
    @(negedge clk);
    got_addr = rs_addr;
    got_res  = {rs_valid, rs_fault, rs_execute_never, rs_region_hit,
                rs_region};
  endtask : access
endmodule : core_access_model

// file: test/memory_protection_unit_tb.sv
// self-checking bench for the memory protection unit
`timescale 1ns/1ps

module memory_protection_unit_tb;
  localparam int NREG = 8;
  localparam prot_pkg::acc_t acc_d = prot_pkg::ACC_DATA;
  localparam prot_pkg::acc_t acc_i = prot_pkg::ACC_IFETCH;
  localparam prot_pkg::acc_t acc_v = prot_pkg::ACC_VECTAB;
  localparam logic [1:0]     ok    = 2'h0;
  localparam logic [1:0]     err   = 2'h2;

  logic                clk;
  logic                sys_rst;
  logic                lk_valid, lk_write, lk_priv, lk_pri_neg;
  logic [31:0]         lk_addr;
  prot_pkg::acc_t      lk_type;
  logic                rs_valid, rs_fault, rs_execute_never, rs_region_hit;
  logic [31:0]         rs_addr, s_rdata;
  logic [2:0]          rs_ap;
  logic [5:0]          rs_attr;
  logic [3:0]          rs_region, s_wstrb;
  logic [31:0]         s_awaddr, s_wdata, s_araddr;
  logic                s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
  logic                s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0]          s_bresp, s_rresp;
  int                  error_cnt;
  int                  cmp_count;

  memory_protection_unit #(.NREG(NREG)) dut (
    .clk(clk), .sys_rst(sys_rst), .lk_valid(lk_valid), .lk_addr(lk_addr),
    .lk_type(lk_type), .lk_write(lk_write), .lk_priv(lk_priv),
    .lk_pri_neg(lk_pri_neg), .rs_valid(rs_valid), .rs_addr(rs_addr),
    .rs_fault(rs_fault), .rs_execute_never(rs_execute_never),
    .rs_ap(rs_ap), .rs_attr(rs_attr), .rs_region_hit(rs_region_hit),
    .rs_region(rs_region), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));

  core_access_model core (
    .clk(clk), .lk_valid(lk_valid), .lk_addr(lk_addr), .lk_type(lk_type),
    .lk_write(lk_write), .lk_priv(lk_priv), .lk_pri_neg(lk_pri_neg),
    .rs_valid(rs_valid), .rs_addr(rs_addr), .rs_fault(rs_fault),
    .rs_execute_never(rs_execute_never), .rs_region_hit(rs_region_hit),
    .rs_region(rs_region));

  // 100 ns clock
  initial clk = 1'b0;
  always #50 clk = ~clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // a used-up wait bound ends the run as a failure
  task automatic tmo(input int n);
    if (n >= 50) begin
      error_cnt++;
      give_verdict();
    end
  endtask : tmo

  // lite write: address and data offered together, held until taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int n;
    @(posedge clk);
    s_awaddr  <= a;
    s_wdata   <= d;
    s_wstrb   <= s;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(s_awready === 1'b1 && s_wready === 1'b1) && n < 50);
    tmo(n);
    s_awvalid <= 1'b0;
    s_wvalid  <= 1'b0;
    s_bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s_bvalid !== 1'b1 && n < 50);
    tmo(n);
    s_bready <= 1'b0;
    check(32'(s_bresp), 32'(er));
  endtask : wr

  // lite read with expected data and response
  task automatic rd(input logic [31:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    int n;
    @(posedge clk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s_arready !== 1'b1 && n < 50);
    tmo(n);
    s_arvalid <= 1'b0;
    s_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (s_rvalid !== 1'b1 && n < 50);
    tmo(n);
    s_rready <= 1'b0;
    check(s_rdata, ed);
    check(32'(s_rresp), 32'(er));
  endtask : rd

  // one lookup; e2 is {fault, xn}; address must come back unchanged
  task automatic acc(input logic [31:0] a, input prot_pkg::acc_t k,
                     input logic wr, input logic pv, input logic hnd,
                     input logic msk, input logic [1:0] e2);
    core.access(a, k, wr, pv, hnd, msk);
    check(32'(core.got_res[7:5]), {29'h0, 1'b1, e2});
    check(core.got_addr, a);
  endtask : acc

  // main sequence
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    sys_rst   = 1'b1;
    {s_awaddr, s_wdata, s_araddr} = '0;
    s_wstrb = 4'h0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(32'h00, 32'(NREG) << 8, ok);
    rd(32'h04, 32'h0, ok);
    rd(32'h40, 32'h0, err);
    wr(32'h04, 32'h1, 4'h3, err);
    rd(32'h04, 32'h0, ok);
    acc(32'h6000_0000, acc_d, 1, 0, 0, 0, 2'b00);
    acc(32'h4000_0000, acc_d, 1, 0, 0, 0, 2'b01);
    acc(32'h4000_0000, acc_i, 0, 1, 0, 0, 2'b11);
    acc(32'h0000_1000, acc_i, 0, 0, 0, 0, 2'b00);
    rd(32'h30, 32'h01, ok);
    wr(32'h30, 32'h83, 4'hF, ok);
    // four regions through the base-select and alias locations
    wr(32'h0C, 32'h2000_0010, 4'hF, ok);
    wr(32'h10, 32'h0306_0219, 4'hF, ok);
    wr(32'h14, 32'h2000_0011, 4'hF, ok);
    wr(32'h18, 32'h0000_000F, 4'hF, ok);
    wr(32'h1C, 32'hE000_0012, 4'hF, ok);
    wr(32'h20, 32'h0300_0039, 4'hF, ok);
    wr(32'h24, 32'h3000_0013, 4'hF, ok);
    wr(32'h28, 32'h0300_0009, 4'hF, ok);
    rd(32'h08, 32'h3, ok);
    rd(32'h0C, 32'h3000_0003, ok);
    rd(32'h10, 32'h0300_0009, ok);
    wr(32'h04, 32'h1, 4'hF, ok);
    acc(32'h2000_1000, acc_d, 1, 0, 0, 0, 2'b00);
    check(32'(core.got_res[4:0]), 32'h10);
    check(32'(rs_attr), 32'h06);
    check(32'(rs_ap), 32'h3);
    acc(32'h2000_1000, acc_i, 0, 0, 0, 0, 2'b00);
    acc(32'h2000_0010, acc_d, 0, 1, 0, 0, 2'b10);
    check(32'(rs_ap), 32'h0);
    acc(32'h2000_0400, acc_d, 1, 1, 0, 0, 2'b10);
    rd(32'h30, 32'h82, ok);
    rd(32'h34, 32'h2000_0400, ok);
    acc(32'h6000_0000, acc_d, 0, 1, 0, 0, 2'b10);
    acc(32'h3000_001C, acc_d, 0, 0, 0, 0, 2'b00);
    acc(32'h3000_0020, acc_d, 0, 0, 0, 0, 2'b10);
    acc(32'hF000_0000, acc_i, 0, 1, 0, 0, 2'b11);
    acc(32'hE000_ED00, acc_d, 1, 0, 0, 0, 2'b01);
    check(32'(core.got_res[4]), 32'h0);
    check(32'(rs_attr), 32'h00);
    acc(32'h0000_0000, acc_v, 0, 0, 0, 0, 2'b00);
    acc(32'h6000_0000, acc_d, 0, 0, 1, 0, 2'b00);
    acc(32'h6000_0000, acc_d, 0, 0, 0, 1, 2'b00);
    wr(32'h04, 32'h3, 4'hF, ok);
    acc(32'h6000_0000, acc_d, 0, 0, 1, 0, 2'b10);
    wr(32'h04, 32'h5, 4'hF, ok);
    acc(32'h2000_0400, acc_d, 1, 1, 0, 0, 2'b00);
    check(32'(core.got_res[4]), 32'h0);
    acc(32'h2000_0400, acc_d, 1, 0, 0, 0, 2'b10);
    // full 4 GB region in the top slot
    wr(32'h0C, 32'h0000_0017, 4'hF, ok);
    wr(32'h10, 32'h0300_003F, 4'hF, ok);
    acc(32'h6000_0000, acc_d, 0, 0, 0, 0, 2'b00);
    check(32'(core.got_res[4:0]), 32'h17);
    wr(32'h04, 32'h0, 4'hF, ok);
    acc(32'h2000_0010, acc_d, 0, 1, 0, 0, 2'b00);
    give_verdict();
  end
endmodule : memory_protection_unit_tb
